// >>> src/uart_efc_defines.svh
// Register map, field positions, reset values and timing constants for the enhanced feature control.
// Operation
// (RULE1) In auto direction mode, wait 0-15 bit times after last stop bit before dropping.
// (RULE2) Turnaround delay field is written only while enhanced write enable is set.
// (RULE3) Transmitter disable halts the transmit shifter; queued bytes stay until cleared.
// (RULE4) Software keeps transmitter disable at 0 when using send-immediate.
// (RULE5) Receiver disable finishes a character in progress, then receives nothing more.
// (RULE6) Re-enabling the receiver on an idle line receives the next character normally.
// (RULE7) Receive FIFO data can be read at any time, receiver disabled or not.
// (RULE8) Transmitter disabled: mode 0 sends only a pending xon/xoff, mode 1 keeps sending.
// (RULE9) Receiver disabled: mode 0 ignores everything, mode 1 still acts on xon/xoff.
// (RULE10) Eight-bit read/write scratch register, reset value 0xFF.
// (RULE11) Tables A-C: flow output drops one trigger level above, returns one below.
// (RULE12) Auto direction mode overrides auto hardware flow control on the output.
// (RULE13) Direction output falls after last stop bit, rises on byte load before start.
// (RULE14) Transmit interrupt on holding empty normally, on shifter empty in direction mode.
// (RULE15) With software flow control, an xon/xoff sent from empty FIFO leaves direction alone.
// (RULE16) Infrared receive polarity: 0 active high input, 1 inverted input.
// (RULE17) Hysteresis select acts only with table D; zero means next-trigger-level behaviour.
// (RULE18) Hysteresis codes map to 0,4,6,8,8,16,24,32,40,44,48,52,12,20,28,36 characters.
// (RULE19) Transmitter and receiver disable bits reset to zero.
// (RULE20) Flow-control select: 0 uses request-to-send, 1 uses data-terminal-ready.
// (RULE21) Turnaround counter counts bit periods and restarts when a new byte is loaded.
`ifndef UART_EFC_DEFINES_SVH
`define UART_EFC_DEFINES_SVH
`define ADDR_TURNAROUND   8'h00
`define ADDR_SCRATCH      8'h04
`define ADDR_FEATURE      8'h08
`define ADDR_CONTROL      8'h0C
`define ADDR_STATUS       8'h10
`define SCRATCH_RESET     8'hFF
`define FEATURE_RESET     8'h00
`define TURN_RESET        8'h00
`define CTRL_RESET        8'h00
`define TA_DELAY_MSB      7
`define TA_DELAY_LSB      4
`define TA_TX_DIS         3
`define TA_RX_DIS         2
`define TA_TX_MODE        1
`define TA_RX_MODE        0
`define FC_TABLE_MSB      7
`define FC_TABLE_LSB      6
`define FC_RS485          5
`define FC_IR_INV         4
`define CT_ENH_WE         0
`define CT_AUTO_FLOW      1
`define CT_FLOW_SEL       2
`define CT_SW_FLOW        3
`define BIT_TICKS_DEF     16'h00AD
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

// >>> src/uart_efc_pkg.sv
// Types shared by the enhanced feature control block.
package uart_efc_pkg;
	typedef enum logic [1:0] {
		TXS_IDLE = 2'b00,
		TXS_SEND = 2'b01,
		TXS_TURN = 2'b10
	} tx_state_t;
	typedef enum logic [1:0] {
		TBL_A = 2'b00,
		TBL_B = 2'b01,
		TBL_C = 2'b10,
		TBL_D = 2'b11
	} table_t;
endpackage

// >>> src/uart_enhanced_feature_control.sv
// Enhanced feature control: turnaround/disable, scratch and feature registers with direction logic.
`timescale 1ns/10ps
`include "uart_efc_defines.svh"
module uart_enhanced_feature_control (
	// Clock, reset and enable.
	input  wire logic        core_clk_i,
	input  wire logic        srst_i,
	input  wire logic        ce_i,
	// AXI4-Lite write address, data and response.
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read.
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Transmit side status from the core.
	input  wire logic        bit_tick_i,
	input  wire logic        tx_fifo_has_data_i,
	input  wire logic        tx_char_done_i,
	input  wire logic        tx_shifter_empty_i,
	input  wire logic        thr_empty_i,
	input  wire logic        xchar_pending_i,
	// Receive side status from the core.
	input  wire logic        rx_busy_i,
	input  wire logic        rx_ir_i,
	input  wire logic        rx_is_flow_char_i,
	input  wire logic [8:0]  rx_level_i,
	input  wire logic [8:0]  rx_trigger_i,
	input  wire logic [8:0]  next_upper_i,
	input  wire logic [8:0]  next_lower_i,
	// Control outputs to the core and pins.
	output logic             tx_shift_en_o,
	output logic             tx_xchar_en_o,
	output logic             rx_shift_en_o,
	output logic             rx_data_accept_o,
	output logic             rx_flow_accept_o,
	output logic             rx_ir_o,
	output logic             tx_irq_o,
	output logic             rts_n_o,
	output logic             dtr_n_o
);
	logic [7:0]              turn_reg;
	logic [7:0]              scratch_reg;
	logic [7:0]              feature_reg;
	logic [7:0]              ctrl_reg;
	uart_efc_pkg::tx_state_t tx_state_reg;
	logic [3:0]              bit_cnt_reg;
	logic                    dir_reg;
	logic                    flow_hold_reg;
	logic                    rx_run_reg;
	logic                    xchar_allow_reg;
	logic                    aw_got_reg;
	logic                    w_got_reg;
	logic [7:0]              aw_addr_reg;
	logic [31:0]             w_data_reg;
	logic                    wr_fire;
	logic                    rd_fire;
	logic                    wr_map;
	logic                    rs485;
	logic                    table_d;
	logic [8:0]              hyst;
	logic [8:0]              hi_mark;
	logic [8:0]              lo_mark;
	logic                    flow_out;

	// Hysteresis in characters for each select code.
	function automatic logic [8:0] hyst_chars(input logic [3:0] code);
		unique case (code)
			4'h0: hyst_chars = 9'h000;
			4'h1: hyst_chars = 9'h004;
			4'h2: hyst_chars = 9'h006;
			4'h3: hyst_chars = 9'h008;
			4'h4: hyst_chars = 9'h008;
			4'h5: hyst_chars = 9'h010;
			4'h6: hyst_chars = 9'h018;
			4'h7: hyst_chars = 9'h020;
			4'h8: hyst_chars = 9'h028;
			4'h9: hyst_chars = 9'h02C;
			4'hA: hyst_chars = 9'h030;
			4'hB: hyst_chars = 9'h034;
			4'hC: hyst_chars = 9'h00C;
			4'hD: hyst_chars = 9'h014;
			4'hE: hyst_chars = 9'h01C;
			4'hF: hyst_chars = 9'h024;
		endcase
	endfunction

	assign rs485   = feature_reg[`FC_RS485];
	assign table_d = feature_reg[`FC_TABLE_MSB:`FC_TABLE_LSB] == uart_efc_pkg::TBL_D; // RULE17
	assign hyst    = hyst_chars(feature_reg[3:0]); // RULE18
	// Table D with code zero falls back to the next trigger levels.
	assign hi_mark = (table_d && hyst != 9'h000) ? rx_trigger_i + hyst : next_upper_i; // RULE11 RULE17
	assign lo_mark = (table_d && hyst != 9'h000) ?
		((rx_trigger_i > hyst) ? rx_trigger_i - hyst : 9'h000) : next_lower_i; // RULE11
	assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign wr_map  = aw_addr_reg == `ADDR_TURNAROUND || aw_addr_reg == `ADDR_SCRATCH ||
		aw_addr_reg == `ADDR_FEATURE || aw_addr_reg == `ADDR_CONTROL;

	// Write channel capture; address and data may arrive in either order.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			aw_got_reg    <= 1'b0;
			w_got_reg     <= 1'b0;
			aw_addr_reg   <= 8'h00;
			w_data_reg    <= 32'h0000_0000;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else if (ce_i) begin
			s_axi_awready <= !aw_got_reg && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_got_reg && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_reg  <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_reg  <= 1'b1;
				w_data_reg <= s_axi_wdata & {{24{1'b0}}, {8{s_axi_wstrb[0]}}};
			end
			if (wr_fire) begin
				aw_got_reg   <= 1'b0;
				w_got_reg    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Register writes; a write with byte lane 0 disabled stores zero, so lane 0 is required.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			turn_reg    <= `TURN_RESET; // RULE19
			scratch_reg <= `SCRATCH_RESET; // RULE10
			feature_reg <= `FEATURE_RESET; // RULE17
			ctrl_reg    <= `CTRL_RESET;
		end else if (ce_i && wr_fire) begin
			unique case (aw_addr_reg)
				`ADDR_TURNAROUND: begin
					if (ctrl_reg[`CT_ENH_WE]) begin
						turn_reg <= w_data_reg[7:0]; // RULE2
					end else begin
						turn_reg[3:0] <= w_data_reg[3:0]; // RULE2
					end
				end
				`ADDR_SCRATCH: scratch_reg <= w_data_reg[7:0]; // RULE10
				`ADDR_FEATURE: feature_reg <= w_data_reg[7:0];
				`ADDR_CONTROL: ctrl_reg <= {4'h0, w_data_reg[3:0]};
				default: ;
			endcase
		end
	end

	// Read channel; the turnaround register is write-only and reads as zero.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else if (ce_i) begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `RESP_OKAY;
				unique case (s_axi_araddr)
					`ADDR_TURNAROUND: s_axi_rdata <= 32'h0000_0000;
					`ADDR_SCRATCH:    s_axi_rdata <= {24'h00_0000, scratch_reg};
					`ADDR_FEATURE:    s_axi_rdata <= {24'h00_0000, feature_reg};
					`ADDR_CONTROL:    s_axi_rdata <= {24'h00_0000, ctrl_reg};
					`ADDR_STATUS:     s_axi_rdata <= {26'h0, tx_state_reg, bit_cnt_reg};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Direction sequencer: high on byte load, low after stop bit plus turnaround delay.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			tx_state_reg <= uart_efc_pkg::TXS_IDLE;
			bit_cnt_reg  <= 4'h0;
			dir_reg      <= 1'b0;
		end else if (ce_i) begin
			unique case (tx_state_reg)
				uart_efc_pkg::TXS_IDLE: begin
					// A flow character sent from an empty FIFO does not turn the bus.
					if (tx_fifo_has_data_i && !turn_reg[`TA_TX_DIS]) begin // RULE15
						dir_reg      <= 1'b1; // RULE13
						tx_state_reg <= uart_efc_pkg::TXS_SEND;
					end
				end
				uart_efc_pkg::TXS_SEND: begin
					if (tx_char_done_i && tx_shifter_empty_i && !tx_fifo_has_data_i) begin
						bit_cnt_reg <= turn_reg[`TA_DELAY_MSB:`TA_DELAY_LSB]; // RULE1
						if (turn_reg[`TA_DELAY_MSB:`TA_DELAY_LSB] == 4'h0) begin
							dir_reg      <= 1'b0; // RULE13
							tx_state_reg <= uart_efc_pkg::TXS_IDLE;
						end else begin
							tx_state_reg <= uart_efc_pkg::TXS_TURN;
						end
					end
				end
				uart_efc_pkg::TXS_TURN: begin
					if (tx_fifo_has_data_i) begin
						tx_state_reg <= uart_efc_pkg::TXS_SEND; // RULE21
					end else if (bit_tick_i) begin
						bit_cnt_reg <= bit_cnt_reg - 4'h1; // RULE21
						if (bit_cnt_reg == 4'h1) begin
							dir_reg      <= 1'b0; // RULE1
							tx_state_reg <= uart_efc_pkg::TXS_IDLE;
						end
					end
				end
				default: tx_state_reg <= uart_efc_pkg::TXS_IDLE;
			endcase
		end
	end

	// Receiver gate: a character already started completes before the halt takes hold.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			rx_run_reg <= 1'b1;
		end else if (ce_i) begin
			if (turn_reg[`TA_RX_DIS] && !rx_busy_i) begin
				rx_run_reg <= 1'b0; // RULE5
			end else if (!turn_reg[`TA_RX_DIS] && !rx_busy_i) begin
				rx_run_reg <= 1'b1; // RULE6
			end
		end
	end

	// Flow character permission kept after a mode 0 transmitter disable until no flow character is pending.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			xchar_allow_reg <= 1'b1;
		end else if (ce_i) begin
			if (!turn_reg[`TA_TX_DIS] || turn_reg[`TA_TX_MODE]) begin
				xchar_allow_reg <= 1'b1; // RULE8
			end else if (!xchar_pending_i) begin
				xchar_allow_reg <= 1'b0; // RULE8
			end
		end
	end

	// Auto flow control hold with hysteresis between the two marks.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			flow_hold_reg <= 1'b0;
		end else if (ce_i) begin
			if (rx_level_i >= hi_mark) begin
				flow_hold_reg <= 1'b1; // RULE11
			end else if (rx_level_i < lo_mark) begin
				flow_hold_reg <= 1'b0; // RULE11
			end
		end
	end

	// In direction mode the selected pin is high while transmitting, which enables the driver.
	assign flow_out = rs485 ? dir_reg : // RULE12
		(ctrl_reg[`CT_AUTO_FLOW] ? flow_hold_reg : 1'b0);

	// Registered outputs.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			tx_shift_en_o    <= 1'b1;
			tx_xchar_en_o    <= 1'b1;
			rx_shift_en_o    <= 1'b1;
			rx_data_accept_o <= 1'b1;
			rx_flow_accept_o <= 1'b1;
			rx_ir_o          <= 1'b0;
			tx_irq_o         <= 1'b0;
			rts_n_o          <= 1'b1;
			dtr_n_o          <= 1'b1;
		end else if (ce_i) begin
			tx_shift_en_o    <= !turn_reg[`TA_TX_DIS]; // RULE3
			tx_xchar_en_o    <= xchar_allow_reg; // RULE8
			rx_shift_en_o    <= rx_run_reg || turn_reg[`TA_RX_MODE]; // RULE9
			rx_data_accept_o <= rx_run_reg; // RULE7 RULE9
			rx_flow_accept_o <= rx_run_reg || (turn_reg[`TA_RX_MODE] && rx_is_flow_char_i); // RULE9
			rx_ir_o          <= rx_ir_i ^ feature_reg[`FC_IR_INV]; // RULE16
			tx_irq_o         <= rs485 ? tx_shifter_empty_i : thr_empty_i; // RULE14
			rts_n_o          <= ctrl_reg[`CT_FLOW_SEL] ? 1'b1 : flow_out; // RULE20
			dtr_n_o          <= ctrl_reg[`CT_FLOW_SEL] ? flow_out : 1'b1; // RULE20
		end
	end

	tx_disable_halts_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE3
		ce_i && turn_reg[`TA_TX_DIS] |=> !tx_shift_en_o)
		else $error("Transmit shifter not halted while disabled.");
	scratch_reset_val_a: assert property (@(posedge core_clk_i) // RULE10
		srst_i |=> scratch_reg == `SCRATCH_RESET)
		else $error("Scratch register did not reset to FF.");
	ir_polarity_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE16
		ce_i |=> rx_ir_o == ($past(rx_ir_i) ^ $past(feature_reg[`FC_IR_INV])))
		else $error("Infrared polarity wrong.");
	tx_irq_source_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE14
		ce_i && rs485 |=> tx_irq_o == $past(tx_shifter_empty_i))
		else $error("Transmit interrupt source wrong in direction mode.");
	turn_guard_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE2
		ce_i && wr_fire && aw_addr_reg == `ADDR_TURNAROUND && !ctrl_reg[`CT_ENH_WE]
		|=> $stable(turn_reg[7:4]))
		else $error("Delay field changed without write enable.");
	dir_rise_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE13
		ce_i && tx_state_reg == uart_efc_pkg::TXS_IDLE && tx_fifo_has_data_i &&
		!turn_reg[`TA_TX_DIS] |=> dir_reg)
		else $error("Direction not raised on byte load.");
	turn_hold_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE1
		tx_state_reg == uart_efc_pkg::TXS_TURN |-> dir_reg)
		else $error("Direction dropped before turnaround expired.");
	rs485_override_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE12
		ce_i && rs485 && !ctrl_reg[`CT_FLOW_SEL] |=> rts_n_o == $past(dir_reg))
		else $error("Flow control overrode direction.");
	rx_halt_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE5
		ce_i && turn_reg[`TA_RX_DIS] && !rx_busy_i |=> !rx_run_reg)
		else $error("Receiver not halted when idle and disabled.");
	hyst_table_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE18
		feature_reg[3:0] == 4'h8 |-> hyst == 9'h028)
		else $error("Hysteresis code 8 not 40.");
endmodule

// >>> testbench/rs485_peer_model.sv
// Behavioural transmit core and baud tick source facing the enhanced feature control block.
`timescale 1ns/10ps
module rs485_peer_model (
	// Clock and reset.
	input  wire logic core_clk_i,
	input  wire logic srst_i,
	// Shifter enable from the block and byte load from the bench.
	input  wire logic tx_shift_en_i,
	input  wire logic load_i,
	// Status towards the block.
	output logic      bit_tick_o,
	output logic      has_data_o,
	output logic      char_done_o,
	output logic      shifter_empty_o,
	output logic      thr_empty_o
);
	logic [2:0] div_reg;
	logic [3:0] count_reg;
	logic [3:0] bits_reg;
	logic       armed_reg;
	logic       busy_reg;
	logic [1:0] done_reg;
	logic       finish;
	assign bit_tick_o = (div_reg == 3'h7);
	assign finish = busy_reg && bit_tick_o && (bits_reg == 4'h0);
	assign has_data_o = (count_reg != 4'h0);
	assign shifter_empty_o = !busy_reg;
	assign thr_empty_o = ((count_reg - {3'h0, busy_reg}) == 4'h0);
	// The done pulse lags the last tick by two cycles so it never shares a cycle with a tick.
	assign char_done_o = done_reg[1];
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			div_reg <= 3'h0;
			count_reg <= 4'h0;
			bits_reg <= 4'h0;
			armed_reg <= 1'b0;
			busy_reg <= 1'b0;
			done_reg <= 2'h0;
		end else begin
			div_reg <= div_reg + 3'h1;
			done_reg <= {done_reg[0], finish};
			count_reg <= count_reg + {3'h0, load_i} - {3'h0, finish};
			if (bit_tick_o && busy_reg)
				bits_reg <= bits_reg - 4'h1;
			if (finish)
				busy_reg <= 1'b0;
			// A byte must wait a whole bit time before its start bit, like a real shifter.
			if (bit_tick_o && !busy_reg) begin
				armed_reg <= has_data_o;
				if (armed_reg && has_data_o && tx_shift_en_i) begin
					busy_reg <= 1'b1;
					bits_reg <= 4'h9;
					armed_reg <= 1'b0;
				end
			end
		end
	end
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the enhanced feature control block.
`timescale 1ns/10ps
`include "uart_efc_defines.svh"
module tb;
	logic        core_clk_i, srst_i, load;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        bit_tick_i, tx_fifo_has_data_i, tx_char_done_i, tx_shifter_empty_i, thr_empty_i;
	logic        xchar_pending_i, rx_busy_i, rx_ir_i, rx_is_flow_char_i;
	logic [8:0]  rx_level_i, rx_trigger_i, next_upper_i, next_lower_i;
	logic        tx_shift_en_o, tx_xchar_en_o, rx_shift_en_o, rx_data_accept_o, rx_flow_accept_o;
	logic        rx_ir_o, tx_irq_o, rts_n_o, dtr_n_o;
	int          err_total = 0, n_compared = 0, cyc = 0, n_tick;
	// Code 0 falls back to the next trigger levels, set here two characters around the trigger.
	int          hyst [16] = '{2, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};

	uart_enhanced_feature_control i_dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(1'b1),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .bit_tick_i(bit_tick_i),
		.tx_fifo_has_data_i(tx_fifo_has_data_i), .tx_char_done_i(tx_char_done_i),
		.tx_shifter_empty_i(tx_shifter_empty_i), .thr_empty_i(thr_empty_i),
		.xchar_pending_i(xchar_pending_i), .rx_busy_i(rx_busy_i), .rx_ir_i(rx_ir_i),
		.rx_is_flow_char_i(rx_is_flow_char_i), .rx_level_i(rx_level_i),
		.rx_trigger_i(rx_trigger_i), .next_upper_i(next_upper_i), .next_lower_i(next_lower_i),
		.tx_shift_en_o(tx_shift_en_o), .tx_xchar_en_o(tx_xchar_en_o),
		.rx_shift_en_o(rx_shift_en_o), .rx_data_accept_o(rx_data_accept_o),
		.rx_flow_accept_o(rx_flow_accept_o), .rx_ir_o(rx_ir_o), .tx_irq_o(tx_irq_o),
		.rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o));
	rs485_peer_model i_peer (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.tx_shift_en_i(tx_shift_en_o), .load_i(load), .bit_tick_o(bit_tick_i),
		.has_data_o(tx_fifo_has_data_i), .char_done_o(tx_char_done_i),
		.shifter_empty_o(tx_shifter_empty_i), .thr_empty_o(thr_empty_i));

	initial begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		if (err_total == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk_i);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		rsp = s_axi_bresp;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		@(posedge core_clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk_i);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask
	task automatic settle();
		repeat (4) @(posedge core_clk_i);
	endtask
	task automatic pulse_load();
		@(posedge core_clk_i);
		load <= 1'b1;
		@(posedge core_clk_i);
		load <= 1'b0;
	endtask
	// Selector 0 waits for the shifter to start, 1 for the end-of-character pulse.
	task automatic wait_ev(input int sel);
		int n;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
		end while ((sel == 0 ? tx_shifter_empty_i !== 1'b0 : tx_char_done_i !== 1'b1) && n < 400);
		chk("wait bound", 32'h0, {31'h0, n >= 400});
	endtask
	task automatic set_lvl(input int v, input logic exp);
		@(posedge core_clk_i);
		rx_level_i <= v[8:0];
		settle();
		chk("flow pin", {31'h0, exp}, {31'h0, rts_n_o});
	endtask
	task automatic measure(input int d, input bit restart);
		int lows;
		lows = 0;
		pulse_load();
		wait_ev(0);
		repeat (2) @(posedge core_clk_i);
		chk("dir before start", 32'h1, {31'h0, rts_n_o});
		chk("irq while shifting", 32'h0, {31'h0, tx_irq_o});
		wait_ev(1);
		if (restart) begin
			repeat (20) @(posedge core_clk_i);
			pulse_load();
			for (int i = 0; i < 400 && tx_char_done_i !== 1'b1; i++) begin
				@(posedge core_clk_i);
				lows += (rts_n_o !== 1'b1);
			end
			chk("dir held on reload", 32'h0, lows);
		end
		n_tick = 0;
		for (int i = 0; i < 200; i++) begin
			@(posedge core_clk_i);
			if (rts_n_o === 1'b0)
				break;
			n_tick += (bit_tick_i === 1'b1);
		end
		chk("turnaround ticks", d, n_tick);
	endtask

	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, load, xchar_pending_i, rx_busy_i} = '0;
		{rx_ir_i, rx_is_flow_char_i, rx_level_i} = '0;
		s_axi_wstrb = 4'hF;
		rx_trigger_i = 9'h064;
		next_upper_i = 9'h066;
		next_lower_i = 9'h062;
		srst_i = 1'b1;
		repeat (6) @(posedge core_clk_i);
		srst_i <= 1'b0;
		axi_rd(`ADDR_SCRATCH);
		chk("scratch reset", 32'h000000FF, rd);
		chk("tx enabled", 32'h1, {31'h0, tx_shift_en_o});
		chk("rx enabled", 32'h1, {31'h0, rx_shift_en_o});
		axi_wr(`ADDR_SCRATCH, 32'h1234ABCD);
		chk("write resp", {30'h0, `RESP_OKAY}, {30'h0, rsp});
		axi_rd(`ADDR_SCRATCH);
		chk("scratch rw", 32'h000000CD, rd);
		axi_rd(8'h40);
		chk("unmapped", {30'h0, `RESP_SLVERR}, {30'h0, rsp});
		axi_wr(8'h40, 32'h00000000);
		chk("unmapped write", {30'h0, `RESP_SLVERR}, {30'h0, rsp});
		rx_ir_i <= 1'b1;
		settle();
		chk("ir normal", 32'h1, {31'h0, rx_ir_o});
		axi_wr(`ADDR_FEATURE, 32'h00000010);
		settle();
		chk("ir inverted", 32'h0, {31'h0, rx_ir_o});
		axi_wr(`ADDR_CONTROL, 32'h00000001);
		rx_busy_i <= 1'b1;
		axi_wr(`ADDR_TURNAROUND, 32'h0000000F);
		axi_rd(`ADDR_TURNAROUND);
		chk("write-only reads", 32'h0, rd);
		chk("tx halted", 32'h0, {31'h0, tx_shift_en_o});
		chk("rx finishes char", 32'h1, {31'h0, rx_shift_en_o});
		chk("xchar mode1", 32'h1, {31'h0, tx_xchar_en_o});
		chk("rx data busy", 32'h1, {31'h0, rx_data_accept_o});
		chk("rx flow mode1", 32'h1, {31'h0, rx_flow_accept_o});
		rx_busy_i <= 1'b0;
		xchar_pending_i <= 1'b1;
		rx_is_flow_char_i <= 1'b1;
		axi_wr(`ADDR_TURNAROUND, 32'h0000000C);
		settle();
		chk("rx halted", 32'h0, {31'h0, rx_shift_en_o});
		chk("rx data off", 32'h0, {31'h0, rx_data_accept_o});
		chk("xchar pending", 32'h1, {31'h0, tx_xchar_en_o});
		chk("rx flow mode0", 32'h0, {31'h0, rx_flow_accept_o});
		xchar_pending_i <= 1'b0;
		axi_wr(`ADDR_TURNAROUND, 32'h0000000D);
		settle();
		chk("xchar mode0", 32'h0, {31'h0, tx_xchar_en_o});
		chk("rx flow mode1 idle", 32'h1, {31'h0, rx_flow_accept_o});
		chk("rx data mode1", 32'h0, {31'h0, rx_data_accept_o});
		rx_is_flow_char_i <= 1'b0;
		pulse_load();
		repeat (40) @(posedge core_clk_i);
		chk("byte stays queued", 32'h1, {31'h0, tx_shifter_empty_i});
		axi_wr(`ADDR_TURNAROUND, 32'h00000000);
		wait_ev(0);
		repeat (2) @(posedge core_clk_i);
		chk("irq holding empty", 32'h1, {31'h0, tx_irq_o});
		chk("rx resumed", 32'h1, {31'h0, rx_shift_en_o});
		wait_ev(1);
		axi_wr(`ADDR_FEATURE, 32'h00000020);
		axi_wr(`ADDR_CONTROL, 32'h00000000);
		axi_wr(`ADDR_TURNAROUND, 32'h00000050);
		measure(0, 1'b0);
		axi_wr(`ADDR_CONTROL, 32'h00000001);
		foreach (hyst[k]) if (k == 3 || k == 15) begin
			axi_wr(`ADDR_TURNAROUND, k << 4);
			measure(k, 1'b0);
		end
		axi_wr(`ADDR_TURNAROUND, 32'h00000070);
		measure(7, 1'b1);
		axi_wr(`ADDR_CONTROL, 32'h00000003);
		set_lvl(150, 1'b0);
		axi_wr(`ADDR_FEATURE, 32'h00000005);
		set_lvl(0, 1'b0);
		set_lvl(110, 1'b1);
		set_lvl(100, 1'b1);
		set_lvl(90, 1'b0);
		axi_wr(`ADDR_CONTROL, 32'h00000007);
		set_lvl(0, 1'b1);
		chk("dtr selected low", 32'h0, {31'h0, dtr_n_o});
		set_lvl(150, 1'b1);
		chk("dtr selected", 32'h1, {31'h0, dtr_n_o});
		axi_wr(`ADDR_CONTROL, 32'h00000003);
		for (int c = 0; c < 16; c++) begin
			axi_wr(`ADDR_FEATURE, 32'h000000C0 | c);
			set_lvl(0, 1'b0);
			set_lvl(100 + hyst[c] - 1, 1'b0);
			set_lvl(100 + hyst[c] + 1, 1'b1);
			set_lvl(100 - hyst[c] + 1, 1'b1);
			set_lvl(100 - hyst[c] - 1, 1'b0);
		end
		tally_and_finish();
	end
endmodule
